// ### dcob_pkg.sv
package dcob_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int IN_CYCLE_MS = 2;
  localparam int SLOW_CYCLE_MS = 8;
  localparam int NS_PER_MS = 1_000_000;
  // Cycles per 2 ms processing period
  localparam int IN_CYCLE_CLKS = (IN_CYCLE_MS * NS_PER_MS) / CLK_PERIOD_NS;
  // Fast periods per slow refresh period
  localparam int SLOW_PER_FAST = SLOW_CYCLE_MS / IN_CYCLE_MS;
  localparam int CNT_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Object indexes and subindexes
  localparam logic [15:0] IDX_OP_CMD = 16'h2000;
  localparam logic [15:0] IDX_SPEED = 16'h2010;
  localparam logic [15:0] IDX_TORQUE = 16'h2020;
  localparam logic [15:0] IDX_TORQUE_COMP = 16'h2030;
  localparam logic [15:0] IDX_READ_REQ = 16'h2040;
  localparam logic [15:0] IDX_STATUS_MON = 16'h2100;
  localparam logic [15:0] IDX_READ_RESP = 16'h2140;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_VALUE = 8'h01;
  localparam logic [7:0] SUB_ADDR = 8'h02;
  localparam logic [31:0] ENTRIES_LINKED = 32'h0000_0002;
  localparam logic [31:0] ENTRIES_SINGLE = 32'h0000_0001;

  ////////////////////////////////////////////////////////////////////////////
  // Linked drive registers
  localparam logic [15:0] DRV_REG_OP_CMD = 16'h0001;
  localparam logic [15:0] DRV_REG_SPEED = 16'h0002;
  localparam logic [15:0] DRV_REG_TORQUE = 16'h0004;
  localparam logic [15:0] DRV_REG_TORQUE_COMP = 16'h0005;

  ////////////////////////////////////////////////////////////////////////////
  // Command word fields and selector codes
  localparam int OP_FWD_BIT = 0;
  localparam int OP_REV_BIT = 1;
  localparam int OP_TERM_LSB = 2;
  localparam int OP_TERM_COUNT = 6;
  localparam int OP_EXT_FAULT_BIT = 8;
  localparam int OP_FAULT_RESET_BIT = 9;
  localparam int REQ_ADDR_LSB = 16;
  localparam logic [3:0] RUN_SRC_NETWORK = 4'h3;
  localparam logic TORQUE_CTRL_SPEED = 1'b0;
  localparam logic TORQUE_CTRL_TORQUE = 1'b1;
  localparam logic TORQUE_REF_ENABLED = 1'b1;
  localparam logic [15:0] RST_WORD16 = 16'h0000;
  localparam logic [31:0] RST_WORD32 = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_ISSUE = 3'b010,
    RD_WAIT = 3'b100
  } dcob_rd_state_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [15:0] index;
    logic [7:0] subindex;
    logic [31:0] wrData;
  } dcob_obj_req_type;

  typedef struct packed {
    logic runForward;
    logic runReverse;
    logic [OP_TERM_COUNT-1:0] terminalIn;
    logic externalFaultInput;
    logic faultReset;
    logic [15:0] speedReference;
    logic [15:0] speedLimit;
    logic [1:0] speedUnit;
    logic [15:0] torqueReference;
    logic [15:0] torqueLimit;
    logic [15:0] torqueCompensation;
  } dcob_drive_cmd_type;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [1:0] slowCnt;
    logic [15:0] opWord;
    logic [15:0] speedWord;
    logic [15:0] torqueWord;
    logic [15:0] compWord;
    logic [31:0] readReqWord;
    logic reqPending;
    dcob_rd_state_type rdState;
    logic [15:0] rdHold;
    logic rdFresh;
    logic [15:0] respValue;
    logic [15:0] statusValue;
    dcob_drive_cmd_type cmd;
    logic rdReq;
    logic [15:0] rdAddr;
    logic [31:0] objRdData;
    logic objRdValid;
    logic objError;
  } dcob_state_type;

endpackage : dcob_pkg

// ### dcob_drive_command_bank.sv
`timescale 1ns/1ps
`default_nettype none

module dcob_drive_command_bank
  import dcob_pkg::*;
#(
  parameter int TICK_CLKS = IN_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Object dictionary access from the fieldbus side
  input wire dcob_obj_req_type objReq,
  output logic [31:0] objRdData,
  output logic objRdValid,
  output logic objError,
  // Drive configuration selections
  input wire logic [3:0] runCommandSourceSelect,
  input wire logic torqueControlSelect,
  input wire logic [1:0] speedUnitSelect,
  input wire logic torqueRefEnableSelect,
  // Drive status monitor
  input wire logic [15:0] driveStatusWord,
  // Commands into the drive
  output dcob_drive_cmd_type driveCmd,
  // Drive register read port
  output logic drvRdReq,
  output logic [15:0] drvRdAddr,
  input wire logic drvRdValid,
  input wire logic [15:0] drvRdData
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  dcob_state_type state;
  dcob_state_type next_state;
  logic tickFast;
  logic tickSlow;
  logic wrHit;
  logic rdHit;
  logic [31:0] rdWord;
  logic networkRun;
  logic torqueMode;
  logic torqueEnabled;
  logic [OP_TERM_COUNT-1:0] termBits;

  // Counter bounds sized once to avoid width mismatch
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CLKS - 1);
  localparam logic [1:0] SLOW_LAST = 2'(SLOW_PER_FAST - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Period ticks

  // fixed period
  // Free running, nothing software can reach alters the count
  assign tickFast = (state.cnt == CNT_LAST);
  // Every fourth fast tick carries the slow refresh
  assign tickSlow = tickFast && (state.slowCnt == SLOW_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // Selection decode

  // network source
  // Run bits from any other source give stop, never latch
  assign networkRun = (runCommandSourceSelect == RUN_SRC_NETWORK);
  assign torqueMode = (torqueControlSelect == TORQUE_CTRL_TORQUE);
  // enable gate
  // Settings are levels, read only at the period edge
  assign torqueEnabled = (torqueRefEnableSelect == TORQUE_REF_ENABLED);

  //////////////////////////////////////////////////////////////////////////////
  // Terminal inputs

  // terminal mapping
  // Bit 2 feeds terminal three, bit 7 terminal eight
  for (genvar t = 0; t < OP_TERM_COUNT; t++) begin : gen_term
    assign termBits[t] = state.opWord[OP_TERM_LSB + t];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_state = state;
    wrHit = 1'b0;
    rdHit = 1'b0;
    rdWord = RST_WORD32;
    next_state.rdReq = 1'b0;
    next_state.objRdValid = 1'b0;
    next_state.objError = 1'b0;

    // Period counters wrap at the tick
    if (tickFast) begin
      next_state.cnt = '0;
      next_state.slowCnt = tickSlow ? 2'b00 : state.slowCnt + 2'b01;
    end else begin
      next_state.cnt = state.cnt + CNT_W'(1);
    end

    // Object writes, only subindex 1 is writable
    if (objReq.write) begin
      if (objReq.subindex == SUB_VALUE) begin
        wrHit = 1'b1;
        case (objReq.index)
          IDX_OP_CMD: begin
            next_state.opWord = objReq.wrData[15:0];
          end
          IDX_SPEED: begin
            next_state.speedWord = objReq.wrData[15:0];
          end
          IDX_TORQUE: begin
            next_state.torqueWord = objReq.wrData[15:0];
          end
          IDX_TORQUE_COMP: begin
            next_state.compWord = objReq.wrData[15:0];
          end
          IDX_READ_REQ: begin
            next_state.readReqWord = objReq.wrData;
            next_state.reqPending = 1'b1;
          end
          default: begin
            wrHit = 1'b0;
          end
        endcase
      end
      next_state.objError = !wrHit;
    end

    // Object reads, answered one cycle later
    // A read beside a write in one cycle sees the old value
    if (objReq.read) begin
      rdHit = 1'b1;
      case (objReq.index)
        IDX_OP_CMD, IDX_SPEED, IDX_TORQUE, IDX_TORQUE_COMP: begin
          case (objReq.subindex)
            SUB_COUNT: begin
              rdWord = ENTRIES_LINKED;
            end
            SUB_VALUE: begin
              case (objReq.index)
                IDX_OP_CMD: begin
                  rdWord = {16'h0000, state.opWord};
                end
                IDX_SPEED: begin
                  rdWord = {16'h0000, state.speedWord};
                end
                IDX_TORQUE: begin
                  rdWord = {16'h0000, state.torqueWord};
                end
                default: begin
                  rdWord = {16'h0000, state.compWord};
                end
              endcase
            end
            SUB_ADDR: begin
              case (objReq.index)
                IDX_OP_CMD: begin
                  rdWord = {16'h0000, DRV_REG_OP_CMD};
                end
                IDX_SPEED: begin
                  rdWord = {16'h0000, DRV_REG_SPEED};
                end
                IDX_TORQUE: begin
                  rdWord = {16'h0000, DRV_REG_TORQUE};
                end
                default: begin
                  rdWord = {16'h0000, DRV_REG_TORQUE_COMP};
                end
              endcase
            end
            default: begin
              rdHit = 1'b0;
            end
          endcase
        end
        IDX_READ_REQ, IDX_READ_RESP, IDX_STATUS_MON: begin
          case (objReq.subindex)
            SUB_COUNT: begin
              rdWord = ENTRIES_SINGLE;
            end
            SUB_VALUE: begin
              case (objReq.index)
                IDX_READ_REQ: begin
                  rdWord = state.readReqWord;
                end
                IDX_READ_RESP: begin
                  rdWord = {16'h0000, state.respValue};
                end
                default: begin
                  rdWord = {16'h0000, state.statusValue};
                end
              endcase
            end
            default: begin
              rdHit = 1'b0;
            end
          endcase
        end
        default: begin
          rdHit = 1'b0;
        end
      endcase
      next_state.objRdValid = 1'b1;
      next_state.objRdData = rdHit ? rdWord : RST_WORD32;
      next_state.objError = !rdHit || next_state.objError;
    end

    // input processing
    // Written objects reach the drive only at the period edge
    if (tickFast) begin
      next_state.cmd.runForward = networkRun && state.opWord[OP_FWD_BIT];
      next_state.cmd.runReverse = networkRun && state.opWord[OP_REV_BIT];
      next_state.cmd.terminalIn = termBits;
      next_state.cmd.externalFaultInput = state.opWord[OP_EXT_FAULT_BIT];
      next_state.cmd.faultReset = state.opWord[OP_FAULT_RESET_BIT];
      // upper bits unused
      // Bits 10 to 15 have no consumer and are only stored

      // unit tag
      // Unit travels with the value; scaling belongs to the drive
      next_state.cmd.speedUnit = speedUnitSelect;
      if (torqueMode) begin
        next_state.cmd.speedReference = RST_WORD16;
        next_state.cmd.speedLimit = state.speedWord;
      end else begin
        next_state.cmd.speedReference = state.speedWord;
        next_state.cmd.speedLimit = RST_WORD16;
      end

      // torque role
      // Disabled torque yields zero on both roles
      next_state.cmd.torqueReference = RST_WORD16;
      next_state.cmd.torqueLimit = RST_WORD16;
      if (torqueEnabled) begin
        if (torqueMode) begin
          next_state.cmd.torqueReference = state.torqueWord;
        end else begin
          next_state.cmd.torqueLimit = state.torqueWord;
        end
      end

      next_state.cmd.torqueCompensation = state.compWord;
    end

    // output refresh
    // Read result at 2 ms, status monitor at the slower 8 ms
    if (tickFast && state.rdFresh) begin
      next_state.respValue = state.rdHold;
      next_state.rdFresh = 1'b0;
    end
    if (tickSlow) begin
      next_state.statusValue = driveStatusWord;
    end

    // Drive register read sequence
    case (state.rdState)
      RD_IDLE: begin
        if (tickFast && state.reqPending) begin
          next_state.rdState = RD_ISSUE;
        end
      end
      RD_ISSUE: begin
        // address field
        // Lower half is expected zero and is not checked
        next_state.rdReq = 1'b1;
        next_state.rdAddr = state.readReqWord[REQ_ADDR_LSB +: 16];
        // New write in this cycle keeps the request pending
        next_state.reqPending = objReq.write && wrHit && (objReq.index == IDX_READ_REQ);
        next_state.rdState = RD_WAIT;
      end
      RD_WAIT: begin
        // response capture
        // No timeout; a silent drive holds off later reads
        if (drvRdValid) begin
          next_state.rdHold = drvRdData;
          next_state.rdFresh = 1'b1;
          next_state.rdState = RD_IDLE;
        end
      end
      default: begin
        next_state.rdState = RD_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Clear everything, then the idle state code
      state <= '0;
      state.rdState <= RD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register

  assign objRdData = state.objRdData;
  assign objRdValid = state.objRdValid;
  assign objError = state.objError;
  assign driveCmd = state.cmd;
  assign drvRdReq = state.rdReq;
  assign drvRdAddr = state.rdAddr;

endmodule : dcob_drive_command_bank

`default_nettype wire

// ### dcob_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the command bank
module dcob_bank_monitor
  import dcob_pkg::*;
#(
  parameter int TICK_CLKS = IN_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Object side
  input wire dcob_obj_req_type objReq,
  input wire logic objRdValid,
  input wire logic objError,
  // Drive side
  input wire logic [3:0] runCommandSourceSelect,
  input wire logic torqueControlSelect,
  input wire logic [1:0] speedUnitSelect,
  input wire logic torqueRefEnableSelect,
  input wire dcob_drive_cmd_type driveCmd,
  input wire logic drvRdReq
);
  logic [CNT_W-1:0] tk;
  logic t1, t2;
  logic [7:0] cfgPrev;
  logic [2:0] cfgAge;
  logic [7:0] cfg;
  // Own period counter; settings must be quiet around a tick to judge the result
  assign cfg = {runCommandSourceSelect, torqueControlSelect, speedUnitSelect, torqueRefEnableSelect};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tk <= '0;
      {t1, t2, cfgPrev, cfgAge} <= '0;
    end else begin
      tk <= (tk == CNT_W'(TICK_CLKS - 1)) ? '0 : tk + 1'b1;
      t1 <= (tk == CNT_W'(TICK_CLKS - 1));
      t2 <= t1;
      cfgPrev <= cfg;
      cfgAge <= (cfg != cfgPrev) ? 3'h0 : (cfgAge == 3'h7 ? cfgAge : cfgAge + 1'b1);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  read_answer_a: assert property (objReq.read |=> objRdValid)
    else $error("read not answered");
  no_stray_answer_a: assert property (!objReq.read |=> !objRdValid)
    else $error("answer without read");
  ro_write_error_a: assert property (objReq.write && objReq.subindex == SUB_ADDR |=> objError)
    else $error("address subindex written");
  cmd_on_tick_a: assert property (!$stable(driveCmd) |-> t1 || t2)
    else $error("command moved off tick");
  run_gate_a: assert property (t2 && cfgAge > 3'h3 && runCommandSourceSelect != RUN_SRC_NETWORK
    |-> !driveCmd.runForward && !driveCmd.runReverse) else $error("run without network source");
  speed_role_a: assert property (t2 && cfgAge > 3'h3 && !torqueControlSelect |-> driveCmd.speedLimit == 16'h0000)
    else $error("speed limit in speed mode");
  torque_gate_a: assert property (t2 && cfgAge > 3'h3 && !torqueRefEnableSelect |->
    driveCmd.torqueReference == 16'h0000 && driveCmd.torqueLimit == 16'h0000) else $error("torque not gated");
  unit_follow_a: assert property (t2 && cfgAge > 3'h3 |-> driveCmd.speedUnit == speedUnitSelect)
    else $error("speed unit mismatch");
  rd_issue_a: assert property (drvRdReq |-> ($past(t1) || $past(t2)) ##1 !drvRdReq)
    else $error("drive read off tick");
  cover property (drvRdReq);
  cover property (objError);
  cover property (t2 && driveCmd.runForward);
endmodule : dcob_bank_monitor
bind dcob_drive_command_bank dcob_bank_monitor #(.TICK_CLKS(TICK_CLKS)) monitor (.clk_sys, .rst_n, .objReq,
  .objRdValid, .objError, .runCommandSourceSelect, .torqueControlSelect, .speedUnitSelect,
  .torqueRefEnableSelect, .driveCmd, .drvRdReq);
`default_nettype wire

// ### dcob_drive_reg_model.sv
`timescale 1ns/1ps
`default_nettype none
// Drive register source, alternating quick and slow answers
module dcob_drive_reg_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Read port
  input wire logic drvRdReq,
  input wire logic [15:0] drvRdAddr,
  output logic drvRdValid,
  output logic [15:0] drvRdData
);
  logic [5:0] dly;
  logic slow;
  logic [15:0] addr;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dly <= 6'h00;
      slow <= 1'b0;
      addr <= 16'h0000;
      drvRdValid <= 1'b0;
      drvRdData <= 16'hFFFF;
    end else begin
      drvRdValid <= 1'b0;
      // Data toggles outside answers so stale values never look valid
      drvRdData <= ~drvRdData;
      if (drvRdReq) begin
        addr <= drvRdAddr;
        dly <= slow ? 6'h1E : 6'h01;
        slow <= ~slow;
      end else if (dly == 6'h01) begin
        drvRdValid <= 1'b1;
        drvRdData <= addr ^ 16'h5A5A;
        dly <= 6'h00;
      end else if (dly != 6'h00) begin
        dly <= dly - 1'b1;
      end
    end
  end
endmodule : dcob_drive_reg_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dcob_pkg::*;
;
  localparam int TK = 20;
  logic clk_sys, rst_n, objRdValid, objError, torqueControlSelect, torqueRefEnableSelect, drvRdReq, drvRdValid;
  logic [3:0] runCommandSourceSelect;
  logic [1:0] speedUnitSelect;
  logic [15:0] driveStatusWord, drvRdAddr, drvRdData, w, a;
  logic [31:0] objRdData;
  logic [9:0] opBits;
  dcob_obj_req_type objReq;
  dcob_drive_cmd_type driveCmd;
  int miscompares = 0;
  int testsRun = 0;
  logic [15:0] idxTab [4] = '{IDX_OP_CMD, IDX_SPEED, IDX_TORQUE, IDX_TORQUE_COMP};
  logic [15:0] regTab [4] = '{DRV_REG_OP_CMD, DRV_REG_SPEED, DRV_REG_TORQUE, DRV_REG_TORQUE_COMP};
  assign opBits = {driveCmd.faultReset, driveCmd.externalFaultInput, driveCmd.terminalIn, driveCmd.runReverse,
    driveCmd.runForward};
  dcob_drive_command_bank #(.TICK_CLKS(TK)) DUT (.clk_sys, .rst_n, .objReq, .objRdData, .objRdValid, .objError,
    .runCommandSourceSelect, .torqueControlSelect, .speedUnitSelect, .torqueRefEnableSelect, .driveStatusWord,
    .driveCmd, .drvRdReq, .drvRdAddr, .drvRdValid, .drvRdData);
  dcob_drive_reg_model drive (.clk_sys, .rst_n, .drvRdReq, .drvRdAddr, .drvRdValid, .drvRdData);
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One object access; the answer pulse is looked at in its single cycle
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                     input logic expErr, input logic [31:0] expData);
    objReq = '{write: wr, read: !wr, index: idx, subindex: sub, wrData: d};
    @(negedge clk_sys);
    objReq = '0;
    if (!wr) chk(32'(objRdValid), 32'h0000_0001);
    if (!wr) chk(objRdData, expData);
    chk(32'(objError), 32'(expErr));
    @(negedge clk_sys);
  endtask : acc
  // Longest write-to-command latency, fixed by the period
  task automatic tk_wait();
    repeat (TK + 3) @(negedge clk_sys);
  endtask : tk_wait
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    // Tests need some forty periods; this allows a thousand
    repeat (1000 * TK) @(negedge clk_sys);
    miscompares++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    objReq = '0;
    runCommandSourceSelect = RUN_SRC_NETWORK;
    {torqueControlSelect, torqueRefEnableSelect, speedUnitSelect} = 4'h0;
    driveStatusWord = 16'h1357;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, idxTab[i], SUB_COUNT, 32'h0000_0000, 1'b0, ENTRIES_LINKED);
      acc(1'b0, idxTab[i], SUB_ADDR, 32'h0000_0000, 1'b0, {16'h0000, regTab[i]});
      acc(1'b0, idxTab[i], SUB_VALUE, 32'h0000_0000, 1'b0, RST_WORD32);
    end
    for (int b = 0; b <= 10; b++) begin
      w = (b == 10) ? 16'hFC00 : 16'h0001 << b;
      acc(1'b1, IDX_OP_CMD, SUB_VALUE, {16'h0000, w}, 1'b0, 32'h0000_0000);
      tk_wait();
      chk(32'(opBits), 32'(w[9:0]));
    end
    acc(1'b0, IDX_OP_CMD, SUB_VALUE, 32'h0000_0000, 1'b0, 32'h0000_FC00);
    acc(1'b1, IDX_OP_CMD, SUB_VALUE, 32'h0000_0003, 1'b0, 32'h0000_0000);
    runCommandSourceSelect = 4'h0;
    tk_wait();
    chk(32'(opBits), 32'h0000_0000);
    acc(1'b1, IDX_SPEED, SUB_VALUE, 32'h0000_1234, 1'b0, 32'h0000_0000);
    acc(1'b1, IDX_TORQUE, SUB_VALUE, 32'h0000_0ABC, 1'b0, 32'h0000_0000);
    acc(1'b1, IDX_TORQUE_COMP, SUB_VALUE, 32'h0000_0055, 1'b0, 32'h0000_0000);
    for (int m = 0; m < 6; m++) begin
      torqueControlSelect = m[0];
      torqueRefEnableSelect = m[1];
      speedUnitSelect = 2'(m / 2);
      tk_wait();
      chk(32'(driveCmd.speedReference), m[0] ? 32'h0000_0000 : 32'h0000_1234);
      chk(32'(driveCmd.speedLimit), m[0] ? 32'h0000_1234 : 32'h0000_0000);
      chk(32'(driveCmd.torqueReference), (m[0] && m[1]) ? 32'h0000_0ABC : 32'h0000_0000);
      chk(32'(driveCmd.torqueLimit), (!m[0] && m[1]) ? 32'h0000_0ABC : 32'h0000_0000);
      chk(32'(driveCmd.speedUnit), 32'(m / 2));
      chk(32'(driveCmd.torqueCompensation), 32'h0000_0055);
    end
    acc(1'b1, IDX_SPEED, SUB_ADDR, 32'h0000_0009, 1'b1, 32'h0000_0000);
    acc(1'b1, IDX_READ_RESP, SUB_VALUE, 32'h0000_0009, 1'b1, 32'h0000_0000);
    acc(1'b0, 16'h2050, SUB_VALUE, 32'h0000_0000, 1'b1, 32'h0000_0000);
    acc(1'b0, IDX_READ_RESP, SUB_COUNT, 32'h0000_0000, 1'b0, ENTRIES_SINGLE);
    acc(1'b0, IDX_READ_REQ, SUB_ADDR, 32'h0000_0000, 1'b1, 32'h0000_0000);
    acc(1'b0, IDX_SPEED, SUB_ADDR, 32'h0000_0000, 1'b0, 32'h0000_0002);
    for (int r = 0; r < 2; r++) begin
      a = 16'h00A0 + 16'(r);
      acc(1'b1, IDX_READ_REQ, SUB_VALUE, {a, 16'h0000}, 1'b0, 32'h0000_0000);
      for (int i = 0; i < 3 * TK && drvRdReq !== 1'b1; i++) @(negedge clk_sys);
      chk({15'h0000, drvRdReq, drvRdAddr}, {16'h0001, a});
      repeat (3 * TK) @(negedge clk_sys);
      acc(1'b0, IDX_READ_RESP, SUB_VALUE, 32'h0000_0000, 1'b0, 32'(a ^ 16'h5A5A));
      acc(1'b0, IDX_READ_REQ, SUB_VALUE, 32'h0000_0000, 1'b0, {a, 16'h0000});
    end
    acc(1'b0, IDX_STATUS_MON, SUB_VALUE, 32'h0000_0000, 1'b0, 32'h0000_1357);
    // A new status word must show within one slow period
    driveStatusWord = 16'h2468;
    repeat (4 * TK + 3) @(negedge clk_sys);
    acc(1'b0, IDX_STATUS_MON, SUB_VALUE, 32'h0000_0000, 1'b0, 32'h0000_2468);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
